// [common/split_timer_pkg.sv]
// Constants shared by the split auto-reload timer files.
// Assumes an 8-bit register port with a 4-bit address.
`default_nettype none
package split_timer_pkg;
  // Register port shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CLKSEL = 4'h1;
  localparam logic [3:0] OFS_RELOAD_LOW = 4'h2;
  localparam logic [3:0] OFS_RELOAD_HIGH = 4'h3;
  localparam logic [3:0] OFS_COUNT_LOW = 4'h4;
  localparam logic [3:0] OFS_COUNT_HIGH = 4'h5;
  localparam logic [3:0] OFS_IRQ_EN = 4'h6;
  // Control register fields
  localparam int BIT_HIGH_OVF = 7;
  localparam int BIT_LOW_OVF = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_EXT_SEL = 0;
  // Clock select and interrupt enable fields
  localparam int BIT_HIGH_CLK_SEL = 1;
  localparam int BIT_LOW_CLK_SEL = 0;
  localparam int BIT_TIMER_IRQ_EN = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_BIT = 1'b0;
  // Count limits and prescaler ratios
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  // Operating modes, Gray coded
  typedef enum logic [1:0]
  {
    MODE_WIDE = 2'b00,
    MODE_SPLIT = 2'b01,
    MODE_HOLD = 2'b11
  } mode_t;
endpackage
`default_nettype wire

// [hw/split_timer_tick.sv]
// Count tick sources: system clock / 12 and external clock / 8.
// Assumes ext_clk_i is asynchronous and slower than half of clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module split_timer_tick #(
  parameter int SYS_DIV = split_timer_pkg::SYS_DIV,
  parameter int EXT_DIV = split_timer_pkg::EXT_DIV
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ext_clk_i,
  output logic tick_div_sys_o,
  output logic tick_div_ext_o
);
  logic [3:0] sys_cnt_reg;
  logic [2:0] ext_cnt_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic ext_rise;

  // Prescaler for the system clock
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      sys_cnt_reg <= 4'h0;
    else if (sys_cnt_reg == 4'(SYS_DIV - 1))
      sys_cnt_reg <= 4'h0;
    else
      sys_cnt_reg <= sys_cnt_reg + 4'h1;
  end
  assign tick_div_sys_o = (sys_cnt_reg == 4'(SYS_DIV - 1));

  // Two-flop synchroniser, edge taken after it
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= ext_clk_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  assign ext_rise = sync2_reg & ~sync3_reg;

  // Divide synchronised edges down
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ext_cnt_reg <= 3'h0;
    else if (ext_rise)
      ext_cnt_reg <= ext_cnt_reg + 3'h1;
  end
  assign tick_div_ext_o = ext_rise & (ext_cnt_reg == 3'(EXT_DIV - 1));

  // Prescaler period is exact: eleven quiet cycles, then the next tick
  property p_sys_period;
    @(posedge clk_sys_i) disable iff (rst_i)
    tick_div_sys_o |=> !tick_div_sys_o [*8] ##1 !tick_div_sys_o [*3] ##1 tick_div_sys_o;
  endproperty
  a_sys_period: assert property (p_sys_period) else $error("div12 tick spacing wrong");
endmodule // split_timer_tick
`default_nettype wire

// [hw/split_timer_byte.sv]
// One 8-bit count byte with optional reload on wrap.
// Assumes inc_i is a one-cycle enable on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module split_timer_byte (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic inc_i,
  input wire logic reload_i,
  input wire logic [7:0] reload_val_i,
  input wire logic wr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] count_o,
  output logic wrap_o
);
  logic [7:0] count_reg;

  // Software write wins over counting
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      count_reg <= split_timer_pkg::RST_BYTE;
    else if (wr_i)
      count_reg <= wr_data_i;
    else if (inc_i)
    begin
      if (wrap_o && reload_i)
        count_reg <= reload_val_i;
      else
        count_reg <= count_reg + 8'h01;
    end
  end
  assign count_o = count_reg;
  // Wrap is suppressed when a write replaces the count
  assign wrap_o = inc_i & ~wr_i & (count_reg == split_timer_pkg::BYTE_MAX);

  property p_write_wins;
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_i |=> count_o == $past(wr_data_i);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("count write lost");
endmodule // split_timer_byte
`default_nettype wire

// [hw/auto_reload_split_timer.sv]
// Auto-reload timer: one 16-bit counter or two 8-bit counters.
// Assumes a single-cycle register port master on clk_sys_i.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Counter is two count bytes; 16-bit or split 8-bit auto-reload.
// - Clocks: system clock, system clock/12, or synchronised external/8.
// - Split bit clear runs both bytes as one 16-bit counter.
// - 16-bit wrap loads the reload pair and sets the high flag.
// - With timer interrupt enabled, each 16-bit overflow requests an interrupt.
// - Low interrupt enable adds a request on low byte wraps.
// - Split bit set, capture clear: two separate auto-reload byte timers.
// - In split mode each byte reloads from its own reload byte.
// - In split mode run control gates only the high byte.
// - In split mode, per byte: select bit picks system clock, else external select decides; 16-bit mode uses the low byte select.
// - In split mode each byte wrap sets its own flag.
// - Split mode: high wraps request interrupts, low too if enabled.
// - Hardware never clears flags; software clears them by writing.
// - Low flag set on every low byte wrap in any mode.
// - External select zero means system/12, one means external/8.
module auto_reload_split_timer (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ext_clk_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  logic high_ovf_flag_reg;
  logic low_ovf_flag_reg;
  logic low_ovf_irq_en_reg;
  logic capture_en_reg;
  logic split_mode_sel_reg;
  logic run_ctrl_reg;
  logic ext_clk_sel_reg;
  logic high_byte_clk_sel_reg;
  logic low_byte_clk_sel_reg;
  logic timer_irq_en_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic [7:0] rdata_reg;
  logic [7:0] count_low;
  logic [7:0] count_high;
  logic tick_div_sys;
  logic tick_div_ext;
  logic tick_divided;
  logic tick_low;
  logic tick_high;
  logic inc_low;
  logic inc_high;
  logic reload_low_en;
  logic low_wrap;
  logic high_wrap;
  logic wr_ctrl;
  logic wr_count_low;
  logic wr_count_high;
  split_timer_pkg::mode_t mode;

  // Register write decode
  assign wr_ctrl = wr_i & (addr_i == split_timer_pkg::OFS_CTRL);
  assign wr_count_low = wr_i & (addr_i == split_timer_pkg::OFS_COUNT_LOW);
  assign wr_count_high = wr_i & (addr_i == split_timer_pkg::OFS_COUNT_HIGH);

  // Mode from split and capture bits; capture itself is not built, so split with capture holds
  always_comb
  begin
    case ({split_mode_sel_reg, capture_en_reg})
      2'b00: mode = split_timer_pkg::MODE_WIDE;
      2'b01: mode = split_timer_pkg::MODE_WIDE;
      2'b10: mode = split_timer_pkg::MODE_SPLIT;
      default: mode = split_timer_pkg::MODE_HOLD;
    endcase
  end

  split_timer_tick u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ext_clk_i(ext_clk_i),
    .tick_div_sys_o(tick_div_sys),
    .tick_div_ext_o(tick_div_ext)
  );

  // Per-byte clock choice; 16-bit mode follows the low byte select
  assign tick_divided = ext_clk_sel_reg ? tick_div_ext : tick_div_sys;
  assign tick_low = low_byte_clk_sel_reg ? 1'b1 : tick_divided;
  assign tick_high = high_byte_clk_sel_reg ? 1'b1 : tick_divided;

  // Count enables and carry chaining
  always_comb
  begin
    case (mode)
      split_timer_pkg::MODE_WIDE:
      begin
        inc_low = run_ctrl_reg & tick_low;
        inc_high = low_wrap;
        reload_low_en = high_wrap;
      end
      split_timer_pkg::MODE_SPLIT:
      begin
        inc_low = tick_low;
        inc_high = run_ctrl_reg & tick_high;
        reload_low_en = 1'b1;
      end
      default:
      begin
        inc_low = 1'b0;
        inc_high = 1'b0;
        reload_low_en = 1'b0;
      end
    endcase
  end

  split_timer_byte u_low (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .inc_i(inc_low),
    .reload_i(reload_low_en),
    .reload_val_i(reload_low_reg),
    .wr_i(wr_count_low),
    .wr_data_i(wdata_i),
    .count_o(count_low),
    .wrap_o(low_wrap)
  );

  // High byte reloads on its own wrap in both modes
  split_timer_byte u_high (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .inc_i(inc_high),
    .reload_i(1'b1),
    .reload_val_i(reload_high_reg),
    .wr_i(wr_count_high),
    .wr_data_i(wdata_i),
    .count_o(count_high),
    .wrap_o(high_wrap)
  );

  // Overflow flags: a wrap in the write cycle wins over a clear
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      high_ovf_flag_reg <= split_timer_pkg::RST_BIT;
      low_ovf_flag_reg <= split_timer_pkg::RST_BIT;
    end
    else
    begin
      if (high_wrap)
        high_ovf_flag_reg <= 1'b1;
      else if (wr_ctrl)
        high_ovf_flag_reg <= wdata_i[split_timer_pkg::BIT_HIGH_OVF];
      if (low_wrap)
        low_ovf_flag_reg <= 1'b1;
      else if (wr_ctrl)
        low_ovf_flag_reg <= wdata_i[split_timer_pkg::BIT_LOW_OVF];
    end
  end

  // Control, clock select and enable bits
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      low_ovf_irq_en_reg <= split_timer_pkg::RST_BIT;
      capture_en_reg <= split_timer_pkg::RST_BIT;
      split_mode_sel_reg <= split_timer_pkg::RST_BIT;
      run_ctrl_reg <= split_timer_pkg::RST_BIT;
      ext_clk_sel_reg <= split_timer_pkg::RST_BIT;
      high_byte_clk_sel_reg <= split_timer_pkg::RST_BIT;
      low_byte_clk_sel_reg <= split_timer_pkg::RST_BIT;
      timer_irq_en_reg <= split_timer_pkg::RST_BIT;
    end
    else if (wr_i)
    begin
      case (addr_i)
        split_timer_pkg::OFS_CTRL:
        begin
          low_ovf_irq_en_reg <= wdata_i[split_timer_pkg::BIT_LOW_IRQ_EN];
          capture_en_reg <= wdata_i[split_timer_pkg::BIT_CAPTURE_EN];
          split_mode_sel_reg <= wdata_i[split_timer_pkg::BIT_SPLIT];
          run_ctrl_reg <= wdata_i[split_timer_pkg::BIT_RUN];
          ext_clk_sel_reg <= wdata_i[split_timer_pkg::BIT_EXT_SEL];
        end
        split_timer_pkg::OFS_CLKSEL:
        begin
          high_byte_clk_sel_reg <= wdata_i[split_timer_pkg::BIT_HIGH_CLK_SEL];
          low_byte_clk_sel_reg <= wdata_i[split_timer_pkg::BIT_LOW_CLK_SEL];
        end
        split_timer_pkg::OFS_IRQ_EN:
          timer_irq_en_reg <= wdata_i[split_timer_pkg::BIT_TIMER_IRQ_EN];
        default:
        begin
        end
      endcase
    end
  end

  // Reload bytes, free to change while counting
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reload_low_reg <= split_timer_pkg::RST_BYTE;
      reload_high_reg <= split_timer_pkg::RST_BYTE;
    end
    else if (wr_i && addr_i == split_timer_pkg::OFS_RELOAD_LOW)
      reload_low_reg <= wdata_i;
    else if (wr_i && addr_i == split_timer_pkg::OFS_RELOAD_HIGH)
      reload_high_reg <= wdata_i;
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= 8'h00;
    else if (!rd_i)
      rdata_reg <= 8'h00;
    else
    begin
      case (addr_i)
        split_timer_pkg::OFS_CTRL:
          rdata_reg <= {high_ovf_flag_reg, low_ovf_flag_reg, low_ovf_irq_en_reg,
                        capture_en_reg, split_mode_sel_reg, run_ctrl_reg,
                        1'b0, ext_clk_sel_reg};
        split_timer_pkg::OFS_CLKSEL:
          rdata_reg <= {6'h00, high_byte_clk_sel_reg, low_byte_clk_sel_reg};
        split_timer_pkg::OFS_RELOAD_LOW: rdata_reg <= reload_low_reg;
        split_timer_pkg::OFS_RELOAD_HIGH: rdata_reg <= reload_high_reg;
        split_timer_pkg::OFS_COUNT_LOW: rdata_reg <= count_low;
        split_timer_pkg::OFS_COUNT_HIGH: rdata_reg <= count_high;
        split_timer_pkg::OFS_IRQ_EN: rdata_reg <= {7'h00, timer_irq_en_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign rdata_o = rdata_reg;

  // Request is a level held by the flags, so no event is missed
  assign irq_o = timer_irq_en_reg &
                 (high_ovf_flag_reg | (low_ovf_irq_en_reg & low_ovf_flag_reg));

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  property p_wide_reload;
    (mode == split_timer_pkg::MODE_WIDE) && high_wrap && !wr_count_low && !wr_count_high
    |=> {count_high, count_low} == $past({reload_high_reg, reload_low_reg});
  endproperty
  a_wide_reload: assert property (p_wide_reload) else $error("16-bit reload missed");

  property p_high_flag;
    high_wrap |=> high_ovf_flag_reg;
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag not set");

  property p_low_flag;
    low_wrap |=> low_ovf_flag_reg;
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag not set");

  property p_sticky;
    high_ovf_flag_reg && !wr_ctrl |=> high_ovf_flag_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

  property p_irq_high;
    timer_irq_en_reg && high_ovf_flag_reg |-> irq_o;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("overflow request missing");

  property p_irq_low;
    $rose(low_ovf_flag_reg) && timer_irq_en_reg && low_ovf_irq_en_reg
    && $past(timer_irq_en_reg) && $past(low_ovf_irq_en_reg) |-> irq_o;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("low byte request missing");

  property p_irq_gate;
    !timer_irq_en_reg || (!high_ovf_flag_reg && !low_ovf_irq_en_reg) |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");

  property p_split_high_stop;
    (mode == split_timer_pkg::MODE_SPLIT) && !run_ctrl_reg && !wr_count_high
    |=> count_high == $past(count_high);
  endproperty
  a_split_high_stop: assert property (p_split_high_stop) else $error("high ran while stopped");

  property p_split_low_runs;
    (mode == split_timer_pkg::MODE_SPLIT) && low_byte_clk_sel_reg && !wr_count_low
    && count_low != split_timer_pkg::BYTE_MAX |=> count_low == $past(count_low) + 8'h01;
  endproperty
  a_split_low_runs: assert property (p_split_low_runs) else $error("low byte not counting");

  property p_split_reload;
    (mode == split_timer_pkg::MODE_SPLIT) && low_wrap |=> count_low == $past(reload_low_reg);
  endproperty
  a_split_reload: assert property (p_split_reload) else $error("low reload missed");

  c_wide_wrap: cover property ((mode == split_timer_pkg::MODE_WIDE) && high_wrap);
  c_split_both: cover property ((mode == split_timer_pkg::MODE_SPLIT) && low_wrap ##[1:600] high_wrap);
  c_irq_rise: cover property ($rose(irq_o));
  c_ext_tick: cover property (ext_clk_sel_reg && tick_div_ext && inc_low);
endmodule // auto_reload_split_timer
`default_nettype wire

// [tb/auto_reload_split_timer_tb.sv]
// Self-checking bench for the auto-reload split timer.
// Assumes the register port of the design and no partner model.
`timescale 1ns/1ps
`default_nettype none
module auto_reload_split_timer_tb;
  localparam logic [3:0] A_CTRL = split_timer_pkg::OFS_CTRL;
  localparam logic [3:0] A_CSEL = split_timer_pkg::OFS_CLKSEL;
  localparam logic [3:0] A_RLL = split_timer_pkg::OFS_RELOAD_LOW;
  localparam logic [3:0] A_RLH = split_timer_pkg::OFS_RELOAD_HIGH;
  localparam logic [3:0] A_CL = split_timer_pkg::OFS_COUNT_LOW;
  localparam logic [3:0] A_CH = split_timer_pkg::OFS_COUNT_HIGH;
  localparam logic [3:0] A_IEN = split_timer_pkg::OFS_IRQ_EN;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ext_clk_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] v1;
  logic [7:0] v2;

  // 50 MHz system clock
  always #10 clk_sys_i = ~clk_sys_i;

  auto_reload_split_timer u_dut (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ext_clk_i(ext_clk_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .irq_o(irq_o)
  );

  // Verdict and end of run
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare one value exactly; an unknown bit matches only the same unknown
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // All access tasks start and end just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Two control writes on adjacent edges: exactly one run cycle
  task automatic pulse(input logic [7:0] on_v, input logic [7:0] off_v);
    wr_i <= 1'b1;
    addr_i <= A_CTRL;
    wdata_i <= on_v;
    @(posedge clk_sys_i);
    wdata_i <= off_v;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic get(input logic [3:0] a, output logic [7:0] v);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    get(a, v);
    chk(v, exp);
  endtask

  // Interrupt level after the last write has landed
  task automatic irq(input logic exp);
    #1;
    chk({7'h00, irq_o}, {7'h00, exp});
  endtask

  // Slow external oscillator, well under half the system rate
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      ext_clk_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      ext_clk_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
    repeat (6) @(posedge clk_sys_i);
  endtask

  // Watchdog: tests need a few thousand cycles at most
  initial
  begin
    #1000000;
    n_fail++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    for (int a = 0; a < 8; a++)
      rd(a[3:0], 8'h00);
    wr(4'h7, 8'hA5);
    rd(4'h7, 8'h00);
    // 16-bit wrap loads the reload pair
    wr(A_CSEL, 8'h01);
    wr(A_RLL, 8'h34);
    wr(A_RLH, 8'h12);
    rd(A_RLL, 8'h34);
    rd(A_RLH, 8'h12);
    wr(A_CL, 8'hFF);
    wr(A_CH, 8'hFF);
    rd(A_CL, 8'hFF);
    pulse(8'h04, 8'h00);
    repeat (5) @(posedge clk_sys_i);
    rd(A_CL, 8'h34);
    rd(A_CH, 8'h12);
    rd(A_CTRL, 8'hC0);
    irq(1'b0);
    wr(A_IEN, 8'h01);
    irq(1'b1);
    wr(A_CTRL, 8'h40);
    irq(1'b0);
    wr(A_CTRL, 8'h60);
    irq(1'b1);
    wr(A_CTRL, 8'h20);
    irq(1'b0);
    // Low byte carry into high byte, low flag only
    wr(A_CL, 8'hFF);
    wr(A_CH, 8'h00);
    pulse(8'h24, 8'h20);
    repeat (3) @(posedge clk_sys_i);
    rd(A_CL, 8'h00);
    rd(A_CH, 8'h01);
    rd(A_CTRL, 8'h60);
    irq(1'b1);
    wr(A_CTRL, 8'h00);
    irq(1'b0);
    // Free run on system clock: two reads two cycles apart
    wr(A_CL, 8'h00);
    wr(A_CTRL, 8'h04);
    get(A_CL, v1);
    get(A_CL, v2);
    chk(v2, v1 + 8'h02);
    wr(A_CTRL, 8'h00);
    // Split mode, low byte on idle external clock so it is frozen
    wr(A_CTRL, 8'h09);
    wr(A_CSEL, 8'h02);
    wr(A_RLL, 8'h5A);
    wr(A_RLH, 8'hA5);
    wr(A_CL, 8'hFF);
    wr(A_CH, 8'hFF);
    repeat (5) @(posedge clk_sys_i);
    rd(A_CH, 8'hFF);
    pulse(8'h0D, 8'h09);
    repeat (3) @(posedge clk_sys_i);
    rd(A_CH, 8'hA5);
    rd(A_CL, 8'hFF);
    rd(A_CTRL, 8'h89);
    irq(1'b1);
    ext_pulses(8);
    rd(A_CL, 8'h5A);
    rd(A_CH, 8'hA5);
    rd(A_CTRL, 8'hC9);
    wr(A_CTRL, 8'h49);
    irq(1'b0);
    wr(A_CTRL, 8'h69);
    irq(1'b1);
    wr(A_CTRL, 8'h29);
    irq(1'b0);
    // Split low byte on system clock / 12, then on system clock, high byte stopped
    wr(A_CTRL, 8'h08);
    wr(A_CSEL, 8'h00);
    get(A_CL, v1);
    repeat (10) @(posedge clk_sys_i);
    get(A_CL, v2);
    chk(v2, v1 + 8'h01);
    wr(A_CSEL, 8'h01);
    get(A_CL, v1);
    get(A_CL, v2);
    chk(v2, v1 + 8'h02);
    rd(A_CH, 8'hA5);
    // Split with capture set: neither byte counts, even with run set
    wr(A_CTRL, 8'h1C);
    get(A_CL, v1);
    get(A_CL, v2);
    chk(v2, v1);
    rd(A_CH, 8'hA5);
    stop_test();
  end
endmodule // auto_reload_split_timer_tb
`default_nettype wire
